//--- hw/efr_top.sv
// Top: fault record builder, region sizing and page metadata checker
//
// The core presents a fault report as a one-cycle pulse. For vector 13 or 14, when the enclave
// has the fault record enabled, the block builds the 16-byte record and
// presents it with a one-cycle write strobe and the byte address of the
// record (general register save area base minus 16).
//
// For page-management instructions the core presents the page parameter
// block fields and the metadata flags word with a check strobe; the block
// answers one cycle later with the decoded fields and a pass flag.
//
// Software sets the capability bitmap and component select over Avalon-MM;
// status registers show the region size, record count and last decode result.

// Contract
// - One component per set capability bit
// - Zero bitmap: no extra region
// - Region size from highest selected component
// - Record is 16 bytes below register area
// - Write record only if both bit0s set
// - Future components zero size
// - Address field: fault address or zero
// - Error code at offset 8, rest reserved
// - Page fault code bit 2 forced one
// - Bits 0,1,3,4 pass through unchanged
// - Bit 5 key, bit 15 map fault
// - Four 8-byte parameter block fields
// - Metadata flags plus 56 zero bytes
// - Bits 0-2 grant read, write, execute
// - Bits 3-5 pending, modified, restrict
// - Kind in 15:8, reserved bits zero
// - Kind codes 0 to 4 decoded
// - Faults 13 and 14 reported when selected
module efr_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Fault report from the core
  input wire efr_pkg::efr_fault_t fault_i,
  input wire logic [63:0] gpr_base_i,
  // Fault record write port
  output logic rec_wr_o,
  output logic [63:0] rec_addr_o,
  output efr_pkg::efr_record_t rec_o,
  // Page parameter block check
  input wire logic chk_i,
  input wire logic [63:0] ppb_addr_i,
  input wire logic [255:0] ppb_i,
  input wire logic [63:0] flags_i,
  input wire logic rsvd_zero_i,
  output logic chk_done_o,
  output logic chk_ok_o,
  output efr_pkg::efr_meta_t meta_o,
  output logic [63:0] lin_addr_o,
  output logic [63:0] src_addr_o,
  output logic [63:0] meta_addr_o,
  output logic [63:0] ctrl_addr_o,
  output logic [15:0] region_size_o
);
  // Register word indices
  localparam logic [3:0] REG_CAP = 4'h0;
  localparam logic [3:0] REG_SEL = 4'h1;
  localparam logic [3:0] REG_SIZE = 4'h2;
  localparam logic [3:0] REG_FCNT = 4'h3;
  localparam logic [3:0] REG_META = 4'h4;

  logic [31:0] cap_q; // Capability bitmap
  logic [31:0] sel_q; // Component select field
  logic [15:0] fcnt_q; // Records written
  logic ack_q; // Access answered this cycle
  logic [15:0] size_w; // Region size from sizing logic
  logic rec_en_w; // Fault record enabled
  efr_pkg::efr_meta_t meta_w; // Decoded metadata
  logic report_w; // Fault qualifies for a record

  // Merge a write into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  // Region sizing
  efr_size_calc u_size (
    .cap_bitmap_i(cap_q),
    .select_i(sel_q),
    .region_size_o(size_w),
    .fault_rec_en_o(rec_en_w)
  );

  // Metadata decode
  efr_meta_dec u_meta (
    .flags_i(flags_i),
    .rsvd_zero_i(rsvd_zero_i),
    .ppb_addr_i(ppb_addr_i),
    .meta_o(meta_w)
  );

  // Waitrequest low for one cycle per access, answering on the second cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_q);
    end
  end

  // Software-written capability and select registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cap_q <= 32'h0000_0000;
      sel_q <= 32'h0000_0000;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      if (avs_address_i == REG_CAP) begin
        cap_q <= be_merge(cap_q, avs_writedata_i, avs_byteenable_i);
      end
      if (avs_address_i == REG_SEL) begin
        sel_q <= be_merge(sel_q, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  // Read data, prepared with the answer; unmapped words read zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      unique case (avs_address_i)
        REG_CAP: avs_readdata_o <= cap_q;
        REG_SEL: avs_readdata_o <= sel_q;
        REG_SIZE: avs_readdata_o <= {16'h0000, size_w};
        REG_FCNT: avs_readdata_o <= {16'h0000, fcnt_q};
        REG_META: avs_readdata_o <= {16'h0000, meta_o.kind, 2'b00, chk_ok_o,
                                     meta_o.permission_restrict_flag, meta_o.modified,
                                     meta_o.pending, meta_o.perm_x, meta_o.perm_w};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Qualify a fault: only vectors 13 and 14, and only when enabled
  always_comb begin
    report_w = fault_i.valid && rec_en_w &&
               ((fault_i.vector == efr_pkg::VEC_PF) || (fault_i.vector == efr_pkg::VEC_GP));
  end

  // Build and present the fault record
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rec_wr_o <= 1'b0;
      rec_addr_o <= 64'h0;
      rec_o <= '0;
    end else begin
      rec_wr_o <= report_w;
      if (report_w) begin
        rec_addr_o <= gpr_base_i - 64'(efr_pkg::FAULT_REC_BELOW_GPR);
        rec_o.reserved <= 32'h0000_0000;
        // Address only for page faults, cleared for protection faults
        rec_o.fault_linear_address <= (fault_i.vector == efr_pkg::VEC_PF) ?
                                      fault_i.lin_addr : 64'h0;
        if (fault_i.vector == efr_pkg::VEC_PF) begin
          // Keep defined flags except bit 2, forced to one; zero reserved bits
          rec_o.fault_error_code <= {16'h0000, fault_i.err_code[efr_pkg::EC_ENCLAVE_PAGE_CACHE_MAP], 9'h000,
                                     fault_i.err_code[efr_pkg::EC_PK],
                                     fault_i.err_code[efr_pkg::EC_ID],
                                     fault_i.err_code[efr_pkg::EC_RSVD],
                                     1'b1,
                                     fault_i.err_code[efr_pkg::EC_WR],
                                     fault_i.err_code[efr_pkg::EC_P]};
        end else begin
          rec_o.fault_error_code <= fault_i.err_code;
        end
      end
    end
  end

  // Count written records
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fcnt_q <= 16'h0000;
    end else if (report_w) begin
      fcnt_q <= fcnt_q + 16'h0001;
    end
  end

  // Page parameter block split and metadata check
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      chk_done_o <= 1'b0;
      chk_ok_o <= 1'b0;
      meta_o <= '0;
      lin_addr_o <= 64'h0;
      src_addr_o <= 64'h0;
      meta_addr_o <= 64'h0;
      ctrl_addr_o <= 64'h0;
    end else begin
      chk_done_o <= chk_i;
      if (chk_i) begin
        meta_o <= meta_w;
        // Four 8-byte fields at their byte offsets
        lin_addr_o <= ppb_i[8*efr_pkg::PPB_LIN_OFS +: 64];
        src_addr_o <= ppb_i[8*efr_pkg::PPB_SRC_OFS +: 64];
        meta_addr_o <= ppb_i[8*efr_pkg::PPB_META_OFS +: 64];
        ctrl_addr_o <= ppb_i[8*efr_pkg::PPB_CTRL_OFS +: 64];
        // Pass only when aligned, zeros kept, kind defined
        chk_ok_o <= meta_w.align_ok && meta_w.rsvd_ok && meta_w.kind_known;
      end
    end
  end

  // Region size shown to the frame allocator
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      region_size_o <= 16'h0000;
    end else begin
      region_size_o <= size_w;
    end
  end

  // Record only when both enable bits are set
  a_rec_enable: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rec_wr_o |-> ($past(cap_q[0]) && $past(sel_q[0])))
    else $error("record written while disabled");

  // Qualifying page fault produces a record next cycle
  a_rec_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fault_i.valid && cap_q[0] && sel_q[0] && fault_i.vector == efr_pkg::VEC_PF) |=> rec_wr_o)
    else $error("page fault not recorded");

  // Protection faults clear the address field
  a_gp_addr_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rec_wr_o && $past(fault_i.vector) == efr_pkg::VEC_GP) |-> rec_o.fault_linear_address == 64'h0)
    else $error("protection fault address not cleared");

  // Page fault code has bit 2 set
  a_pf_user_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rec_wr_o && $past(fault_i.vector) == efr_pkg::VEC_PF) |-> rec_o.fault_error_code[2])
    else $error("user bit missing");

  // Reserved record bytes are zero
  a_rsvd_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rec_wr_o |-> (rec_o.reserved == 32'h0))
    else $error("reserved record bytes not zero");

  // Record address sits 16 below the register area
  a_rec_addr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rec_wr_o |-> (rec_addr_o == $past(gpr_base_i) - 64'h10))
    else $error("record address wrong");

  // Zero bitmap gives zero region size
  a_no_region: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cap_q == 32'h0) |=> (region_size_o == 16'h0))
    else $error("region sized without capability");

  // Misaligned block never passes
  a_align_chk: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (chk_i && ppb_addr_i[4:0] != 5'h00) |=> (chk_done_o && !chk_ok_o))
    else $error("misaligned block passed");

  // Unknown kind code never passes
  a_kind_chk: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (chk_i && flags_i[15:8] > 8'h04) |=> !chk_ok_o)
    else $error("reserved kind passed");

  // Page fault code keeps the ordinary fault flags
  a_pf_flag_copy: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rec_wr_o && $past(fault_i.vector) == efr_pkg::VEC_PF) |->
      (rec_o.fault_error_code[4:3] == $past(fault_i.err_code[4:3]) &&
       rec_o.fault_error_code[1:0] == $past(fault_i.err_code[1:0])))
    else $error("page fault flags not kept");

  // Key and map bits carried, reserved code bits zero
  a_pf_code_rsvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rec_wr_o && $past(fault_i.vector) == efr_pkg::VEC_PF) |->
      (rec_o.fault_error_code[31:16] == 16'h0000 && rec_o.fault_error_code[14:6] == 9'h000 &&
       rec_o.fault_error_code[5] == $past(fault_i.err_code[5]) &&
       rec_o.fault_error_code[15] == $past(fault_i.err_code[15])))
    else $error("page fault code bits wrong");

  // Protection fault code is stored whole
  a_gp_code: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rec_wr_o && $past(fault_i.vector) == efr_pkg::VEC_GP) |->
      (rec_o.fault_error_code == $past(fault_i.err_code)))
    else $error("protection fault code not stored");

  // A fault while the record is disabled writes nothing
  a_rec_refused: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fault_i.valid && !(cap_q[0] && sel_q[0])) |=> !rec_wr_o)
    else $error("record written while disabled");

  // Reserved flag bits never pass
  a_flag_rsvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (chk_i && (flags_i & efr_pkg::FL_RSVD_MASK) != 64'h0) |=> !chk_ok_o)
    else $error("reserved flag bits passed");

  // Permission bits follow the flags word
  a_perm_copy: assert property (@(posedge core_clk_i) disable iff (rst_i)
    chk_i |=> (meta_o.perm_r == $past(flags_i[efr_pkg::FL_R]) &&
               meta_o.perm_w == $past(flags_i[efr_pkg::FL_W]) &&
               meta_o.perm_x == $past(flags_i[efr_pkg::FL_X])))
    else $error("permission bits wrong");
endmodule

//--- pkg/efr_pkg.sv
// Package: constants and carrier types for the enclave fault record and page metadata block
package efr_pkg;
  // Capability bitmap and component sizing
  localparam int unsigned CAP_W = 32;
  localparam logic [31:0] CAP_FAULT_REC_BIT = 32'h0000_0001;
  localparam logic [15:0] FAULT_REC_SIZE = 16'h0010;
  localparam logic [15:0] FAULT_REC_BELOW_GPR = 16'h0010;
  // Fault record byte offsets
  localparam logic [3:0] FR_ADDR_OFS = 4'h0;
  localparam logic [3:0] FR_CODE_OFS = 4'h8;
  localparam logic [3:0] FR_RSVD_OFS = 4'hc;
  // Exception vectors
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [7:0] VEC_PF = 8'h0e;
  // Error code bit positions
  localparam int unsigned EC_P = 0;
  localparam int unsigned EC_WR = 1;
  localparam int unsigned EC_US = 2;
  localparam int unsigned EC_RSVD = 3;
  localparam int unsigned EC_ID = 4;
  localparam int unsigned EC_PK = 5;
  localparam int unsigned EC_ENCLAVE_PAGE_CACHE_MAP = 15;
  // Page parameter block byte offsets and alignment
  localparam logic [4:0] PPB_LIN_OFS = 5'h00;
  localparam logic [4:0] PPB_SRC_OFS = 5'h08;
  localparam logic [4:0] PPB_META_OFS = 5'h10;
  localparam logic [4:0] PPB_CTRL_OFS = 5'h18;
  localparam int unsigned PPB_ALIGN_BITS = 5;
  // Page security metadata
  localparam int unsigned META_RSVD_BYTES = 56;
  localparam int unsigned FL_R = 0;
  localparam int unsigned FL_W = 1;
  localparam int unsigned FL_X = 2;
  localparam int unsigned FL_PEND = 3;
  localparam int unsigned FL_MOD = 4;
  localparam int unsigned FL_PR = 5;
  localparam int unsigned FL_KIND_LO = 8;
  localparam logic [63:0] FL_RSVD_MASK = 64'hffff_ffff_ffff_00c0;

  // Page kinds
  typedef enum logic [7:0] {
    KIND_CONTROL_PAGE = 8'h00,
    KIND_THREAD_CONTROL_PAGE = 8'h01,
    KIND_NORMAL_PAGE = 8'h02,
    KIND_VERSION_ARRAY = 8'h03,
    KIND_TRIMMED_PAGE = 8'h04
  } efr_kind_t;

  // Fault report from the core
  typedef struct packed {
    logic valid;
    logic is_pf;
    logic [7:0] vector;
    logic [63:0] lin_addr;
    logic [31:0] err_code;
  } efr_fault_t;

  // Fault record as written to the save frame
  typedef struct packed {
    logic [31:0] reserved;
    logic [31:0] fault_error_code;
    logic [63:0] fault_linear_address;
  } efr_record_t;

  // Decoded page security metadata
  typedef struct packed {
    logic perm_r;
    logic perm_w;
    logic perm_x;
    logic pending;
    logic modified;
    logic permission_restrict_flag;
    logic [7:0] kind;
    logic kind_known;
    logic rsvd_ok;
    logic align_ok;
  } efr_meta_t;
endpackage

//--- hw/efr_size_calc.sv
// Region sizing: extra-information region size from capability and select bits
module efr_size_calc (
  input wire logic [31:0] cap_bitmap_i,
  input wire logic [31:0] select_i,
  output logic [15:0] region_size_o,
  output logic fault_rec_en_o
);
  // Highest selected component decides the size; only the fault record has a size
  always_comb begin
    region_size_o = 16'h0000;
    fault_rec_en_o = 1'b0;
    if (cap_bitmap_i != 32'h0000_0000) begin
      // Future components weigh nothing, whatever the upper capability bits hold
      if ((select_i & cap_bitmap_i & efr_pkg::CAP_FAULT_REC_BIT) != 32'h0) begin
        region_size_o = efr_pkg::FAULT_REC_SIZE;
        fault_rec_en_o = 1'b1;
      end
    end
  end
endmodule

//--- hw/efr_meta_dec.sv
// Page security metadata and page parameter block decode
module efr_meta_dec (
  input wire logic [63:0] flags_i,
  input wire logic rsvd_zero_i,
  input wire logic [63:0] ppb_addr_i,
  output efr_pkg::efr_meta_t meta_o
);
  // Kind code is one of the five defined values
  function automatic logic kind_known(input logic [7:0] k);
    kind_known = (k <= 8'(efr_pkg::KIND_TRIMMED_PAGE));
  endfunction

  // Field decode
  always_comb begin
    meta_o.perm_r = flags_i[efr_pkg::FL_R];
    meta_o.perm_w = flags_i[efr_pkg::FL_W];
    meta_o.perm_x = flags_i[efr_pkg::FL_X];
    meta_o.pending = flags_i[efr_pkg::FL_PEND];
    meta_o.modified = flags_i[efr_pkg::FL_MOD];
    meta_o.permission_restrict_flag = flags_i[efr_pkg::FL_PR];
    meta_o.kind = flags_i[efr_pkg::FL_KIND_LO +: 8];
    meta_o.kind_known = kind_known(flags_i[efr_pkg::FL_KIND_LO +: 8]);
    // Reserved bits and reserved bytes must all be zero
    meta_o.rsvd_ok = ((flags_i & efr_pkg::FL_RSVD_MASK) == 64'h0) && rsvd_zero_i;
    meta_o.align_ok = (ppb_addr_i[efr_pkg::PPB_ALIGN_BITS-1:0] == 5'h00);
  end
endmodule

//--- testbench/efr_frame_mem.sv
// Partner model: save frame memory that takes the fault record writes
module efr_frame_mem (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rec_wr_i,
  input wire logic [63:0] rec_addr_i,
  input wire efr_pkg::efr_record_t rec_i,
  output logic [63:0] last_addr_o,
  output efr_pkg::efr_record_t last_rec_o,
  output logic [31:0] count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Keep the last record whole, as 16 bytes below the register area
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_o <= 32'h0;
      last_addr_o <= 64'h0;
      last_rec_o <= '0;
    end else if (rec_wr_i) begin
      count_o <= count_o + 32'h1;
      last_addr_o <= rec_addr_i;
      last_rec_o <= rec_i;
    end
  end
endmodule

//--- testbench/testbench.sv
// Testbench: register access, fault records and page metadata decode
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic wreq, rwr, done, ok;
  efr_pkg::efr_fault_t flt = '0;
  logic [63:0] gpr = 64'h0;
  logic [63:0] radr, la, sa, ma, ca, m_adr;
  efr_pkg::efr_record_t rec, m_rec;
  logic chk = 1'b0;
  logic [63:0] paddr = 64'h0;
  logic [255:0] ppb = 256'h0;
  logic [63:0] flg = 64'h0;
  logic rz = 1'b0;
  logic [3:0] be = 4'hf;
  logic [49:0] rv;
  efr_pkg::efr_meta_t meta;
  logic [15:0] rsz;
  logic [31:0] m_cnt, cap, sel, cnt;
  int fails = 0;
  int comparisons = 0;

  efr_top u_efr_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .fault_i(flt), .gpr_base_i(gpr),
    .rec_wr_o(rwr), .rec_addr_o(radr), .rec_o(rec), .chk_i(chk), .ppb_addr_i(paddr),
    .ppb_i(ppb), .flags_i(flg), .rsvd_zero_i(rz), .chk_done_o(done), .chk_ok_o(ok),
    .meta_o(meta), .lin_addr_o(la), .src_addr_o(sa), .meta_addr_o(ma), .ctrl_addr_o(ca),
    .region_size_o(rsz));
  efr_frame_mem u_efr_frame_mem (.core_clk_i(core_clk_i), .rst_i(rst_i), .rec_wr_i(rwr),
    .rec_addr_i(radr), .rec_i(rec), .last_addr_o(m_adr), .last_rec_o(m_rec),
    .count_o(m_cnt));

  // Free-running 125 MHz core clock
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Count a comparison and report a difference
  task automatic check_val(input string what, input logic [255:0] seen,
                           input logic [255:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Print counts and the verdict, then stop
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      fails++;
      test_done();
    end
  endtask

  // Expected record contents for a reported fault
  function automatic efr_pkg::efr_record_t exp_rec(input logic [7:0] v,
      input logic [63:0] a, input logic [31:0] ec);
    exp_rec = '0;
    if (v == efr_pkg::VEC_PF) begin
      exp_rec.fault_linear_address = a;
      exp_rec.fault_error_code = {16'h0, ec[15], 9'h0, ec[5:3], 1'b1, ec[1:0]};
    end else begin
      exp_rec.fault_error_code = ec;
    end
  endfunction

  // Present one fault pulse and check the record write that follows
  task automatic fault(input logic [7:0] v);
    logic en;
    logic [63:0] a, g;
    logic [31:0] ec;
    en = cap[0] && sel[0] && (v == efr_pkg::VEC_GP || v == efr_pkg::VEC_PF);
    a = {$urandom, $urandom};
    g = {$urandom, $urandom} & ~64'h7;
    ec = $urandom;
    @(posedge core_clk_i);
    flt <= {1'b1, 1'($urandom), v, a, ec};
    gpr <= g;
    @(posedge core_clk_i);
    flt.valid <= 1'b0;
    @(negedge core_clk_i);
    check_val("rec_wr", rwr, en);
    if (en) begin
      cnt++;
      check_val("rec", rec, exp_rec(v, a, ec));
      check_val("rec_addr", radr, g - 64'h10);
    end
    @(negedge core_clk_i);
    check_val("rec_wr_end", rwr, 1'b0);
    if (en) begin
      check_val("frame_rec", m_rec, exp_rec(v, a, ec));
    end
  endtask

  // Present one page check and compare the decoded result
  task automatic meta_chk(input logic [63:0] f, input logic [63:0] pa, input logic z);
    logic [255:0] pb;
    logic [16:0] em;
    logic eok;
    for (int i = 0; i < 8; i++) begin
      pb[32*i +: 32] = $urandom;
    end
    em = {f[0], f[1], f[2], f[3], f[4], f[5], f[15:8], f[15:8] <= 8'h04,
          (f & efr_pkg::FL_RSVD_MASK) == 64'h0, pa[4:0] == 5'h0};
    eok = em[1] && em[0] && em[2] && z;
    @(posedge core_clk_i);
    chk <= 1'b1;
    ppb <= pb;
    flg <= f;
    paddr <= pa;
    rz <= z;
    @(posedge core_clk_i);
    chk <= 1'b0;
    @(negedge core_clk_i);
    check_val("chk_done", done, 1'b1);
    check_val("chk_ok", ok, eok);
    check_val("meta", {meta[16:2], meta[0]}, {em[16:2], em[0]});
    check_val("meta_rsvd", meta[1], em[1] && z);
    check_val("ppb", {ca, ma, sa, la}, pb);
    @(negedge core_clk_i);
    check_val("chk_done_end", done, 1'b0);
  endtask

  // Bound on the whole run
  initial begin
    repeat (100000) @(posedge core_clk_i);
    fails++;
    test_done();
  end

  // Main sequence
  initial begin
    void'($urandom(40560));
    cnt = 32'h0;
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check_val("reset_state", {wreq, rwr, done, rsz}, {1'b1, 1'b0, 1'b0, 16'h0});
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Every pairing of capability bit 0 and select bit 0, upper bits random, then an all-zero capability bitmap
    for (int c = 0; c < 5; c++) begin
      cap = {$urandom, 1'b0} | 32'(c[0]);
      sel = {$urandom, 1'b0} | 32'(c[1]);
      if (c == 4) begin
        cap = 32'h0;
      end
      bus(1'b1, 4'h0, cap);
      bus(1'b1, 4'h1, sel);
      bus(1'b0, 4'h0, 32'h0);
      check_val("cap_reg", q, cap);
      bus(1'b0, 4'h1, 32'h0);
      check_val("sel_reg", q, sel);
      bus(1'b0, 4'h2, 32'h0);
      check_val("size_reg", q[15:0], (cap[0] && sel[0]) ? 16'h10 : 16'h0);
      check_val("size_port", rsz, (cap[0] && sel[0]) ? 16'h10 : 16'h0);
      fault(efr_pkg::VEC_PF);
      fault(efr_pkg::VEC_GP);
      fault(8'h06);
      fault(8'($urandom));
    end
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0);
    check_val("size_ro", q, 32'h0);
    bus(1'b0, 4'h9, 32'h0);
    check_val("unmapped", q, 32'h0);
    // Single byte lane write lands only in the low byte
    be <= 4'h1;
    bus(1'b1, 4'h0, 32'hffff_ffff);
    be <= 4'hf;
    bus(1'b0, 4'h0, 32'h0);
    check_val("cap_lane", q, 32'h0000_00ff);
    // Record count is read only
    bus(1'b1, 4'h3, 32'h0000_5a5a);
    bus(1'b0, 4'h3, 32'h0);
    check_val("rec_count", q, cnt);
    check_val("frame_count", m_cnt, cnt);
    // Page kinds 0 to 7 with reserved bits, misalignment and nonzero tail
    for (int k = 0; k < 48; k++) begin
      rv = ($urandom % 4 == 0) ? {18'($urandom), $urandom} : 50'h0;
      meta_chk({rv[49:2], 8'(k % 8), rv[1:0], 6'($urandom)}, {$urandom, $urandom} & ~64'h1f
                | (($urandom % 4 == 0) ? 64'(5'($urandom)) : 64'h0),
               ($urandom % 4 != 0));
    end
    meta_chk(64'h0000_0000_0000_0407, 64'h0000_0000_0000_1000, 1'b1);
    // Last check result word after a clean trimmed page
    bus(1'b0, 4'h4, 32'h0);
    check_val("meta_reg", q, {16'h0000, 8'h04, 2'b00, 1'b1, 3'b000, 2'b11});
    test_done();
  end
endmodule
